/* File: rtl/clp_regs.vh */
`ifndef CLP_REGS_VH
`define CLP_REGS_VH
// ****************************************
// function modes
// ****************************************
`define CLP_MODE_DISABLED 2'h0
`define CLP_MODE_ALARM    2'h1
`define CLP_MODE_LATCHED  2'h2
`define CLP_MODE_CONTROL  2'h3
// ****************************************
// setpoint group select
// ****************************************
`define CLP_GRP_1      3'h0
`define CLP_GRP_4      3'h3
`define CLP_GRP_ACTIVE 3'h4
// ****************************************
// thresholds in percent of nominal
// ****************************************
`define CLP_OUTAGE_PCT  8'h05
`define CLP_RESTORE_PCT 8'h0a
// ****************************************
// timer ranges and defaults, raise percent limit
// ****************************************
`define CLP_OUTAGE_MIN     10'h001
`define CLP_OUTAGE_MAX     10'h3e8
`define CLP_OUTAGE_DEF     10'h064
`define CLP_HOLD_MIN       10'h001
`define CLP_HOLD_MAX       10'h3e8
`define CLP_HOLD_DEF       10'h005
`define CLP_RAISE_MAX      7'h64
`define CLP_SEC_PER_MIN    6'h3c
`endif

/* File: rtl/clp_control.v */
`include "clp_regs.vh"
module clp_control (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        clk_en,
    input  wire        sec_tick,
    input  wire [7:0]  phase_a_pct,
    input  wire [7:0]  phase_b_pct,
    input  wire [7:0]  phase_c_pct,
    input  wire        cold_load_force,
    input  wire        alarm_reset,
    input  wire [1:0]  function_mode,
    input  wire [4:0]  relay_select,
    input  wire [9:0]  outage_qualify_time,
    input  wire [9:0]  hold_time,
    input  wire [4:0]  instant_element_block_enable,
    input  wire [34:0] raise_pct,
    input  wire [2:0]  group_select,
    input  wire [1:0]  active_group,
    output reg         cold_load_active,
    output reg         alarm_out,
    output reg  [4:0]  relay_out,
    output reg  [4:0]  instant_block,
    output reg  [34:0] raise_out,
    output reg  [1:0]  group_out
);

// ****************************************
// helpers
// ****************************************
function [9:0] clamp_time;
    input [9:0] val;
    input [9:0] lo;
    input [9:0] hi;
    begin
        if (val < lo) begin
            clamp_time = lo;
        end else if (val > hi) begin
            clamp_time = hi;
        end else begin
            clamp_time = val;
        end
    end
endfunction

function [6:0] clamp_pct;
    input [6:0] val;
    begin
        clamp_pct = (val > `CLP_RAISE_MAX) ? `CLP_RAISE_MAX : val;
    end
endfunction

function all_below;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    input [7:0] thr;
    begin
        all_below = (a < thr) && (b < thr) && (c < thr);
    end
endfunction

function any_above;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    input [7:0] thr;
    begin
        any_above = (a > thr) || (b > thr) || (c > thr);
    end
endfunction

// ****************************************
// state
// ****************************************
localparam [2:0] ST_NORMAL  = 3'h1;
localparam [2:0] ST_COLD    = 3'h2;
localparam [2:0] ST_HOLD    = 3'h4;

reg [2:0]  state;
reg [2:0]  next_state;
reg [5:0]  sec_in_min;
reg [9:0]  outage_min;
reg [9:0]  hold_sec;
reg        latch;

wire       enabled;
wire       all_low;
wire       restored;
wire [9:0] out_lim;
wire [9:0] hold_lim;
wire       min_tick;
wire       outage_ok;
wire       hold_done;
wire       cold_next;

// ****************************************
// current level and timer decode
// ****************************************
assign enabled   = (function_mode != `CLP_MODE_DISABLED);
assign all_low   = all_below(phase_a_pct, phase_b_pct, phase_c_pct, `CLP_OUTAGE_PCT);
assign restored  = any_above(phase_a_pct, phase_b_pct, phase_c_pct, `CLP_RESTORE_PCT);
assign out_lim   = clamp_time(outage_qualify_time, `CLP_OUTAGE_MIN, `CLP_OUTAGE_MAX);
assign hold_lim  = clamp_time(hold_time, `CLP_HOLD_MIN, `CLP_HOLD_MAX);
assign min_tick  = sec_tick && (sec_in_min == `CLP_SEC_PER_MIN - 6'h01);
assign outage_ok = all_low && (outage_min >= out_lim);
assign hold_done = sec_tick && (hold_sec + 10'h001 >= hold_lim);
assign cold_next = (next_state != ST_NORMAL);

// ****************************************
// state machine
// ****************************************
always @* begin
    next_state = state;
    case (state)
        ST_NORMAL: begin
            // a force input skips the outage wait
            if (enabled && (cold_load_force || outage_ok)) begin
                next_state = ST_COLD;
            end
        end
        ST_COLD: begin
            if (restored && !cold_load_force) begin
                next_state = ST_HOLD;
            end
        end
        ST_HOLD: begin
            // a fresh force during the hold returns to full cold load
            if (cold_load_force) begin
                next_state = ST_COLD;
            end else if (hold_done) begin
                next_state = ST_NORMAL;
            end
        end
        default: begin
            // unused codes recover to normal
            next_state = ST_NORMAL;
        end
    endcase
    if (!enabled) begin
        next_state = ST_NORMAL;
    end
end

// ****************************************
// outage timer
// ****************************************
reg [5:0]  next_sec_in_min;
reg [9:0]  next_outage_min;
reg [9:0]  next_hold_sec;

// counts whole minutes, saturating at the top of the range
always @* begin
    next_sec_in_min = sec_in_min;
    next_outage_min = outage_min;
    if (!all_low || state != ST_NORMAL) begin
        next_sec_in_min = 6'h00;
        next_outage_min = 10'h000;
    end else if (sec_tick) begin
        if (min_tick) begin
            next_sec_in_min = 6'h00;
        end else begin
            next_sec_in_min = sec_in_min + 6'h01;
        end
        if (min_tick && outage_min != `CLP_OUTAGE_MAX) begin
            next_outage_min = outage_min + 10'h001;
        end
    end
end

// ****************************************
// restore hold timer
// ****************************************
// counts seconds once current is back
always @* begin
    next_hold_sec = hold_sec;
    if (state != ST_HOLD) begin
        next_hold_sec = 10'h000;
    end else if (sec_tick) begin
        next_hold_sec = hold_sec + 10'h001;
    end
end

// ****************************************
// alarm indication
// ****************************************
reg        next_latch;
reg        next_alarm;
wire       mode_alarm   = (function_mode == `CLP_MODE_ALARM);
wire       mode_latched = (function_mode == `CLP_MODE_LATCHED);

// plain alarm follows the state, latched alarm holds until cleared
always @* begin
    next_latch = latch;
    if (!mode_latched || alarm_reset) begin
        next_latch = 1'b0;
    end
    // a cold load entry wins over a clear in the same cycle
    if (mode_latched && cold_next) begin
        next_latch = 1'b1;
    end
    next_alarm = 1'b0;
    if (mode_alarm) begin
        next_alarm = cold_next;
    end else if (mode_latched) begin
        next_alarm = cold_next || (latch && !alarm_reset);
    end
end

// ****************************************
// protection outputs
// ****************************************
reg [4:0]  next_relay;
reg [4:0]  next_block;
reg [34:0] next_raise;
reg [1:0]  next_group;
wire       ctl_on = cold_next && (function_mode == `CLP_MODE_CONTROL);

// relays follow the cold load state in every enabled mode
// blocking, raise and group act only in control mode
always @* begin
    next_relay = 5'h00;
    next_block = 5'h00;
    next_raise = 35'h0;
    next_group = active_group;
    if (cold_next) begin
        next_relay = relay_select;
    end
    if (ctl_on) begin
        next_block = instant_element_block_enable;
    end
    if (ctl_on) begin
        next_raise = {clamp_pct(raise_pct[34:28]), clamp_pct(raise_pct[27:21]),
                      clamp_pct(raise_pct[20:14]), clamp_pct(raise_pct[13:7]),
                      clamp_pct(raise_pct[6:0])};
    end
    if (ctl_on && group_select <= `CLP_GRP_4) begin
        next_group = group_select[1:0];
    end
end

// ****************************************
// registers
// ****************************************
// all state holds while the clock enable is low
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        state      <= ST_NORMAL;
        sec_in_min <= 6'h00;
        outage_min <= 10'h000;
        hold_sec   <= 10'h000;
    end else if (clk_en) begin
        state      <= next_state;
        sec_in_min <= next_sec_in_min;
        outage_min <= next_outage_min;
        hold_sec   <= next_hold_sec;
    end
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        latch     <= 1'b0;
        alarm_out <= 1'b0;
    end else if (clk_en) begin
        latch     <= next_latch;
        alarm_out <= next_alarm;
    end
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        cold_load_active <= 1'b0;
        relay_out        <= 5'h00;
    end else if (clk_en) begin
        cold_load_active <= cold_next;
        relay_out        <= next_relay;
    end
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        instant_block <= 5'h00;
        raise_out     <= 35'h0;
        group_out     <= 2'h0;
    end else if (clk_en) begin
        instant_block <= next_block;
        raise_out     <= next_raise;
        group_out     <= next_group;
    end
end

endmodule // clp_control

/* File: sim/clp_control_props.sv */
module clp_props (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        sec_tick,
    input wire logic        cold_load_force,
    input wire logic        cold_load_active,
    input wire logic        alarm_out,
    input wire logic [1:0]  function_mode,
    input wire logic [1:0]  group_out,
    input wire logic [2:0]  group_select,
    input wire logic [4:0]  relay_select,
    input wire logic [4:0]  relay_out,
    input wire logic [4:0]  instant_element_block_enable,
    input wire logic [4:0]  instant_block,
    input wire logic [34:0] raise_pct,
    input wire logic [34:0] raise_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence ctl_s;
        $past(function_mode) == 2'h3 && cold_load_active;
    endsequence
    force_in_a: assert property (
        cold_load_force && function_mode != 2'h0 |=> cold_load_active)
        else $error("force not taken");
    mode_off_a: assert property (
        function_mode == 2'h0 |=> !cold_load_active && relay_out == 5'h0)
        else $error("disabled mode acts");
    relay_map_a: assert property (cold_load_active |-> relay_out == $past(relay_select))
        else $error("relay mismatch");
    block_map_a: assert property (
        ctl_s |-> instant_block == $past(instant_element_block_enable))
        else $error("block mismatch");
    idle_out_a: assert property (
        !cold_load_active |-> instant_block == 5'h0 && raise_out == 35'h0)
        else $error("idle outputs active");
    raise_map_a: assert property (ctl_s |-> raise_out == $past(raise_pct))
        else $error("raise mismatch");
    group_map_a: assert property (
        ctl_s ##0 ($past(group_select) < 3'h4) |-> group_out == $past(group_select[1:0]))
        else $error("group mismatch");
    hold_exit_a: assert property (
        $fell(cold_load_active) && $past(function_mode) != 2'h0 |-> $past(sec_tick))
        else $error("exit off tick");
    alarm_follow_a: assert property (
        $past(function_mode) == 2'h1 |-> alarm_out == cold_load_active)
        else $error("alarm not following");
endmodule // clp_props
bind clp_control clp_props u_props (.*);

/* File: sim/clp_feeder.sv */
module clp_feeder (
    input wire logic        ref_clk,
    input wire logic        run,
    input wire logic [7:0]  load,
    output logic [7:0]      phase_a_pct,
    output logic [7:0]      phase_b_pct,
    output logic [7:0]      phase_c_pct,
    output logic            sec_tick = 1'b0
);
    timeunit 1ns; timeprecision 1ps;
    logic [1:0] div = 2'h0;
    // only phase a carries the level, the others stay lower
    assign phase_a_pct = load;
    assign phase_b_pct = load >> 1;
    assign phase_c_pct = load >> 2;
    always @(posedge ref_clk) begin
        div <= div + 2'h1;
        sec_tick <= run && div == 2'h3;
    end
endmodule // clp_feeder

/* File: sim/clp_control_tb.sv */
module clp_control_tb;
    timeunit 1ns; timeprecision 1ps;
    logic ref_clk = 0, rstn = 0, run = 0, force_in = 0, alarm_reset = 0;
    logic [1:0] mode = 0, act = 0, gout; logic [7:0] load = 8'h04, pa, pb, pc;
    logic [4:0] rsel = 0, ben = 0, rly, blk; logic [34:0] rp = 0, rout; logic [2:0] gsel = 0;
    logic [9:0] oqt = 10'h001, hold = 10'h003; logic tick, cold, alarm;
    logic en = 1;
    int error_cnt = 0, num_checks = 0, cyc = 0; integer seed = 32'hb3eb;
    clp_feeder PTN (.ref_clk(ref_clk), .run(run), .load(load), .phase_a_pct(pa),
        .phase_b_pct(pb), .phase_c_pct(pc), .sec_tick(tick));
    clp_control DUT (.ref_clk(ref_clk), .rstn(rstn), .clk_en(en), .sec_tick(tick),
        .phase_a_pct(pa), .phase_b_pct(pb), .phase_c_pct(pc), .cold_load_force(force_in),
        .alarm_reset(alarm_reset), .function_mode(mode), .relay_select(rsel),
        .outage_qualify_time(oqt), .hold_time(hold), .instant_element_block_enable(ben),
        .raise_pct(rp), .group_select(gsel), .active_group(act), .cold_load_active(cold),
        .alarm_out(alarm), .relay_out(rly), .instant_block(blk), .raise_out(rout),
        .group_out(gout));
    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input string n, input logic [34:0] e, input logic [34:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task ticks(input int n);
        int k;
        k = 0;
        run = 1;
        while (k < n) begin
            @(posedge ref_clk);
            if (tick === 1'b1) k++;
        end
        #1 run = 0;
    endtask
    task chk_all(input bit c);
        chk("cold", c, cold);
        chk("relay", c ? rsel : 5'h0, rly);
        chk("block", c && mode == 3 ? ben : 5'h0, blk);
        chk("raise", c && mode == 3 ? rp : 35'h0, rout);
        chk("group", c && mode == 3 && gsel < 4 ? gsel[1:0] : act, gout);
    endtask
    task pulse();
        force_in = 1;
        step(1);
        force_in = 0;
        step(1);
        chk_all(1);
    endtask
    task restore();
        load = 8'h0b;
        step(2);
        ticks(hold - 1);
        chk("hold", 1, cold);
        ticks(1);
        step(2);
        chk_all(0);
        load = 8'h04;
        $display("restore test done");
    endtask
    initial begin
        rsel = $random(seed);
        ben = $random(seed);
        act = $random(seed);
        for (int i = 0; i < 5; i++) rp[i*7 +: 7] = {$random(seed)} % 101;
        step(4);
        rstn = 1;
        force_in = 1;
        step(3);
        force_in = 0;
        chk_all(0);
        $display("reset test done");
        mode = 3;
        for (int g = 0; g < 5; g++) begin
            gsel = g;
            pulse();
            restore();
        end
        $display("group test done");
        ticks(30);
        load = 8'h05;
        ticks(2);
        load = 8'h04;
        ticks(58);
        chk("early", 0, cold);
        en = 0;
        ticks(4);
        chk("frozen", 0, cold);
        en = 1;
        ticks(4);
        step(1);
        chk_all(1);
        $display("outage test done");
        restore();
        for (int m = 1; m < 3; m++) begin
            mode = m;
            pulse();
            chk("alarm", 1, alarm);
            restore();
            chk("latch", m == 2, alarm);
            alarm_reset = 1;
            step(1);
            alarm_reset = 0;
            step(1);
            chk("clear", 0, alarm);
        end
        $display("alarm test done");
        give_verdict();
    end
endmodule // clp_control_tb
